// [hw/eam_pkg.sv]
package eam_pkg;
   // shared address/data lines
   localparam int unsigned AD_W        = 16;
   // read configuration register layout
   localparam int unsigned CFG_W       = 16;
   localparam int unsigned EXT_BIT     = 4;
   localparam int unsigned ASYNC_BIT   = 15;
   localparam int unsigned LAT_LSB     = 11;
   localparam int unsigned LAT_W       = 4;
   localparam logic [15:0] CFG_RST     = 16'h8000;
   // clock
   localparam int unsigned REF_CLK_HZ  = 20_000_000;
   localparam int unsigned REF_CLK_NS  = 1_000_000_000 / REF_CLK_HZ;
endpackage

// [hw/eam_if.sv]
`timescale 1ns/1ps
interface eam_if;
   logic        ce_n;
   logic        addr_valid_strobe_n;
   logic        oe_n;
   logic        we_n;
   logic        bus_clk;
   logic [15:0] host_ad;
   logic        host_ad_en;
   logic [15:0] dev_ad;
   logic        dev_ad_en;
   logic        wait_val;
   logic        wait_en;
   logic [15:0] ad;
   logic        wait_line;

   // wire resolution, undriven lines read as pulled levels
   assign ad = dev_ad_en ? dev_ad : (host_ad_en ? host_ad : 16'hffff);
   assign wait_line = wait_en ? wait_val : 1'b0;

   modport dev
   (
      input  ce_n, addr_valid_strobe_n, oe_n, we_n, bus_clk, ad,
      output dev_ad, dev_ad_en, wait_val, wait_en
   );
   modport host
   (
      output ce_n, addr_valid_strobe_n, oe_n, we_n, bus_clk,
      output host_ad, host_ad_en,
      input  ad, wait_line
   );
endinterface

// [hw/eam_dev.sv]
`timescale 1ns/1ps
// What the link requires
// [R1] mode exists only in shared-bus build
// [R2] config bit 4 enables, reset default off
// [R3] entering mode clears upper address latch
// [R4] both halves captured from shared lines
// [R5] output gate high lower, low upper
// [R6] host sends upper first, then lower
// [R7] lone lower uses last latched upper
// [R8] sensing starts when lower address latched
// [R9] latch lower, drive data after gate falls
// [R10] wait driven exactly while data driven
// [R11] async mode: wait valid whenever driven
// [R12] sync mode: wait valid after latency
// [R13] async and sync reads and writes supported
// [R14] host pulses strobe once or twice
// [R15] gate low first edge, high second
// [R16] dedicated upper pins tied to ground
// [R17] sync cycles capture on clock rise
// [R18] host may hold strobe between phases
module eam_dev
#(
   parameter int unsigned AW        = 24,
   parameter bit          MUX_BUILD = 1'b1
)
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // link
   eam_if.dev                 bus,
   // configuration from command logic
   input  wire logic          cfg_wr,
   input  wire logic [15:0]   cfg_data,
   output logic [15:0]        cfg_q,
   // array core side
   output logic [AW-1:0]      addr_q,
   output logic               sense_start_q,
   output logic               wr_pulse_q,
   output logic [15:0]        wr_data_q,
   input  wire logic [15:0]   rd_data,
   input  wire logic          rd_valid
);
   localparam int unsigned UW      = AW - 16;
   localparam int unsigned LAT_W_L = eam_pkg::LAT_W;

   logic            ext_on;
   logic            async_on;
   logic            ext_prev_q;
   logic            adv_prev_q;
   logic            clk_prev_q;
   logic            we_prev_q;
   logic            clk_rise;
   logic            cap;
   logic            cap_upper;
   logic            cap_lower;
   logic [UW-1:0]   upper_q;
   logic            phase_q;
   logic            read_q;
   logic            ready_q;
   logic [LAT_W_L-1:0] lat_q;
   logic [15:0]     dq_q;
   logic            drive;

   assign ext_on   = cfg_q[eam_pkg::EXT_BIT];
   assign async_on = cfg_q[eam_pkg::ASYNC_BIT];
   assign clk_rise = bus.bus_clk & ~clk_prev_q;

   // address capture event
   always_comb
   begin
      if (async_on)
         cap = ~bus.ce_n & ~adv_prev_q & bus.addr_valid_strobe_n;
      else
         cap = ~bus.ce_n & clk_rise & ~bus.addr_valid_strobe_n; // [R17]
      cap_upper = cap & ~bus.oe_n & ext_on; // [R5]
      cap_lower = cap & bus.oe_n; // [R5]
   end

   // configuration register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         cfg_q <= eam_pkg::CFG_RST; // [R2]
      else if (cfg_wr)
      begin
         cfg_q <= cfg_data;
         cfg_q[eam_pkg::EXT_BIT] <= cfg_data[eam_pkg::EXT_BIT] & MUX_BUILD; // [R1]
      end
   end

   // edge history of pins and of the mode bit
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ext_prev_q <= 1'b0;
         adv_prev_q <= 1'b1;
         clk_prev_q <= 1'b0;
         we_prev_q  <= 1'b1;
      end
      else
      begin
         ext_prev_q <= ext_on;
         adv_prev_q <= bus.addr_valid_strobe_n;
         clk_prev_q <= bus.bus_clk;
         we_prev_q  <= bus.we_n;
      end
   end

   // upper address latch
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         upper_q <= '0;
      else if (ext_on & ~ext_prev_q)
         upper_q <= '0; // [R3]
      else if (cap_upper)
         upper_q <= bus.ad[UW-1:0]; // [R4]
   end

   // full address and sense start
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         addr_q        <= '0;
         sense_start_q <= 1'b0;
      end
      else
      begin
         sense_start_q <= cap_lower & bus.we_n; // [R8]
         if (cap_lower)
            addr_q <= {(ext_on ? upper_q : {UW{1'b0}}), bus.ad}; // [R7]
      end
   end

   // bus cycle phase after lower capture
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         phase_q <= 1'b0;
         read_q  <= 1'b0;
      end
      else if (bus.ce_n)
      begin
         phase_q <= 1'b0;
         read_q  <= 1'b0;
      end
      else if (cap_lower)
      begin
         phase_q <= 1'b1; // [R9]
         read_q  <= bus.we_n;
      end
      // a write shows itself only when its strobe falls
      else if (phase_q & ~bus.we_n)
         read_q  <= 1'b0; // [R13]
   end

   // read data from the core
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ready_q <= 1'b0;
         dq_q    <= '0;
      end
      else
      begin
         if (rd_valid)
         begin
            ready_q <= 1'b1;
            dq_q    <= rd_data;
         end
         else if (cap_lower | bus.ce_n)
            ready_q <= 1'b0;
      end
   end

   // synchronous latency count
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         lat_q <= '0;
      else if (cap_lower)
         lat_q <= cfg_q[eam_pkg::LAT_LSB +: LAT_W_L];
      else if (clk_rise & (lat_q != '0))
         lat_q <= lat_q - 1'b1; // [R12]
   end

   // write data capture on write strobe rise
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_pulse_q <= 1'b0;
         wr_data_q  <= '0;
      end
      else
      begin
         wr_pulse_q <= phase_q & ~read_q & ~bus.ce_n & ~we_prev_q
                       & bus.we_n; // [R13]
         if (phase_q & ~we_prev_q & bus.we_n)
            wr_data_q <= bus.ad;
      end
   end

   // data and wait drive
   always_comb
   begin
      drive = phase_q & read_q & ~bus.ce_n & ~bus.oe_n & bus.we_n
              & (ready_q | ~async_on); // [R9]
      bus.dev_ad    = dq_q;
      bus.dev_ad_en = drive;
      bus.wait_en   = drive; // [R10]
      if (async_on)
         bus.wait_val = 1'b1; // [R11]
      else
         bus.wait_val = ready_q & (lat_q == '0); // [R12]
   end
endmodule

// [hw/eam_host.sv]
`timescale 1ns/1ps
module eam_host
#(
   parameter int unsigned AW = 24
)
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // link
   eam_if.host                bus,
   // user requests
   input  wire logic          req,
   input  wire logic          req_write,
   input  wire logic          req_two,
   input  wire logic          req_sync,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [15:0]   req_wdata,
   output logic               busy,
   output logic               done_q,
   output logic [15:0]        rd_data_q
);
   typedef enum logic [8:0]
   {
      S_IDLE = 9'h001,
      S_UP   = 9'h002,
      S_UPH  = 9'h004,
      S_LO   = 9'h008,
      S_LOH  = 9'h010,
      S_DATA = 9'h020,
      S_WR   = 9'h040,
      S_WRH  = 9'h080,
      S_END  = 9'h100
   } eam_hstate_t;

   eam_hstate_t     st_q;
   eam_hstate_t     st_d;
   logic            clk_q;
   logic            sync_q;
   logic            two_q;
   logic            wr_q;
   logic [AW-1:0]   addr_q;
   logic [15:0]     wdata_q;
   logic            step;
   logic            got;

   assign step = ~sync_q | clk_q;
   assign got  = (st_q == S_DATA) & bus.wait_line;
   assign busy = (st_q != S_IDLE);

   // next state
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         S_IDLE:
            if (req)
               st_d = req_two ? S_UP : S_LO; // [R6]
         S_UP:
            if (step)
               st_d = sync_q ? S_LO : S_UPH; // [R18]
         S_UPH:
            st_d = S_LO;
         S_LO:
            if (step)
               st_d = sync_q ? (wr_q ? S_WR : S_DATA) : S_LOH;
         S_LOH:
            st_d = wr_q ? S_WR : S_DATA;
         S_DATA:
            if (got)
               st_d = S_END;
         S_WR:
            if (step)
               st_d = S_WRH;
         S_WRH:
            if (step)
               st_d = S_END;
         S_END:
            st_d = S_IDLE;
         default:
            st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         st_q <= S_IDLE;
      else
         st_q <= st_d;
   end

   // request latch
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync_q  <= 1'b0;
         two_q   <= 1'b0;
         wr_q    <= 1'b0;
         addr_q  <= '0;
         wdata_q <= '0;
      end
      else if ((st_q == S_IDLE) & req)
      begin
         sync_q  <= req_sync;
         two_q   <= req_two;
         wr_q    <= req_write;
         addr_q  <= req_addr;
         wdata_q <= req_wdata;
      end
   end

   // link clock, one rise per sync address phase and two per write phase (S_WR, S_WRH), toggling on while read data is awaited
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         clk_q <= 1'b0;
      else if (sync_q & (st_q != S_IDLE) & (st_d != S_IDLE)
               & (st_d != S_END))
         clk_q <= ~clk_q; // [R17]
      else
         clk_q <= 1'b0;
   end

   // read result
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         done_q    <= 1'b0;
         rd_data_q <= '0;
      end
      else
      begin
         done_q <= (st_q == S_END);
         if (got)
            rd_data_q <= bus.ad;
      end
   end

   // pins from one-hot state
   always_comb
   begin
      bus.bus_clk             = clk_q;
      bus.ce_n                = (st_q == S_IDLE) | (st_q == S_END);
      bus.addr_valid_strobe_n = ~((st_q == S_UP) | (st_q == S_LO)); // [R14]
      bus.oe_n                = ~((st_q == S_UP) | (st_q == S_UPH)
                                  | (st_q == S_DATA)); // [R15]
      bus.we_n                = ~(st_q == S_WR);
      bus.host_ad_en          = ~((st_q == S_IDLE) | (st_q == S_DATA)
                                  | (st_q == S_END));
      if ((st_q == S_UP) | (st_q == S_UPH))
         bus.host_ad = 16'(addr_q[AW-1:16]);
      else if ((st_q == S_WR) | (st_q == S_WRH))
         bus.host_ad = wdata_q;
      else
         bus.host_ad = addr_q[15:0];
   end
endmodule

// [tb/eam_checker.sv]
`timescale 1ns/1ps
module eam_checker
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // link
   input wire logic ce_n,
   input wire logic addr_valid_strobe_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic bus_clk,
   input wire logic host_ad_en,
   input wire logic dev_ad_en,
   input wire logic wait_val,
   input wire logic wait_en
);
   logic       str_q;
   logic       sync_q;
   logic [2:0] cnt_q;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // strobe history
   always_ff @(posedge ref_clk)
      str_q <= addr_valid_strobe_n;
   // sync cycle seen
   always_ff @(posedge ref_clk)
      if (rst || ce_n)
         sync_q <= 1'b0;
      else if (bus_clk)
         sync_q <= 1'b1;
   // strobe pulses per cycle
   always_ff @(posedge ref_clk)
      if (rst || ce_n)
         cnt_q <= 3'h0;
      else if (addr_valid_strobe_n && !str_q)
         cnt_q <= cnt_q + 3'h1;

   sequence up_cap;
      $rose(addr_valid_strobe_n) && !oe_n && !ce_n && !sync_q;
   endsequence
   sequence lo_cap;
      $rose(addr_valid_strobe_n) && oe_n && !ce_n;
   endsequence

   wait_dv_a: assert property (wait_en == dev_ad_en)
      else $error("wait enable differs from data enable");
   gate_drive_a: assert property (dev_ad_en |-> !oe_n && !ce_n && we_n)
      else $error("device drives outside read gate");
   no_fight_a: assert property (!(dev_ad_en && host_ad_en))
      else $error("both ends drive the lines");
   async_wait_a: assert property (wait_en && !sync_q |-> wait_val)
      else $error("async wait not valid");
   sync_wait_a: assert property ($rose(wait_en) && sync_q |-> !wait_val)
      else $error("sync wait valid too early");
   pulse_cnt_a: assert property (cnt_q <= 3'h2)
      else $error("more than two strobe pulses");
   min_pulse_a: assert property ($rose(ce_n) && !sync_q |-> cnt_q != 3'h0)
      else $error("cycle without strobe pulse");
   half_order_a: assert property (up_cap |-> ##2 lo_cap)
      else $error("lower half not after upper");
   idle_clk_a: assert property (ce_n |-> !bus_clk)
      else $error("link clock outside cycle");
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam int unsigned AW = 24;
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   logic          req = 1'b0;
   logic          req_write = 1'b0;
   logic          req_two = 1'b0;
   logic          req_sync = 1'b0;
   logic [AW-1:0] req_addr = 24'h0;
   logic [15:0]   req_wdata = 16'h0;
   logic          busy;
   logic          done_q;
   logic [15:0]   rd_data_q;
   logic          cfg_wr = 1'b0;
   logic [15:0]   cfg_data = 16'h0;
   logic [15:0]   cfg_q;
   logic [AW-1:0] addr_q;
   logic          sense_start_q;
   logic          wr_pulse_q;
   logic [15:0]   wr_data_q;
   logic [15:0]   rd_data = 16'h0;
   logic          rd_valid = 1'b0;
   logic [AW-1:0] s_addr = 24'h0;
   logic [AW-1:0] w_addr = 24'h0;
   logic [AW-1:0] s_cnt = 24'h0;
   logic [15:0]   w_data = 16'h0;
   int            n_fail = 0;
   int            check_count = 0;

   eam_if eam_if_i ();
   eam_dev #(.AW(AW)) eam_dev_i
   (
      .ref_clk(ref_clk), .rst(rst), .bus(eam_if_i), .cfg_wr(cfg_wr),
      .cfg_data(cfg_data), .cfg_q(cfg_q), .addr_q(addr_q),
      .sense_start_q(sense_start_q), .wr_pulse_q(wr_pulse_q),
      .wr_data_q(wr_data_q), .rd_data(rd_data), .rd_valid(rd_valid)
   );
   eam_host #(.AW(AW)) eam_host_i
   (
      .ref_clk(ref_clk), .rst(rst), .bus(eam_if_i), .req(req),
      .req_write(req_write), .req_two(req_two), .req_sync(req_sync),
      .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
      .done_q(done_q), .rd_data_q(rd_data_q)
   );
   eam_checker eam_checker_i
   (
      .ref_clk(ref_clk), .rst(rst), .ce_n(eam_if_i.ce_n),
      .addr_valid_strobe_n(eam_if_i.addr_valid_strobe_n),
      .oe_n(eam_if_i.oe_n), .we_n(eam_if_i.we_n),
      .bus_clk(eam_if_i.bus_clk), .host_ad_en(eam_if_i.host_ad_en),
      .dev_ad_en(eam_if_i.dev_ad_en), .wait_val(eam_if_i.wait_val),
      .wait_en(eam_if_i.wait_en)
   );

   initial
   begin
      forever #(eam_pkg::REF_CLK_NS / 2) ref_clk = ~ref_clk;
   end

   // array core stand-in
   always @(posedge ref_clk)
   begin
      #1;
      if (wr_pulse_q === 1'b1)
      begin
         w_addr = addr_q;
         w_data = wr_data_q;
      end
      if (sense_start_q === 1'b1)
      begin
         s_addr = addr_q;
         s_cnt = s_cnt + 24'h1;
         rd_data = addr_q[15:0] ^ 16'h5a5a;
         rd_valid = 1'b1;
         @(posedge ref_clk);
         #1 rd_valid = 1'b0;
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cfg(input logic [15:0] d);
      @(posedge ref_clk);
      #1 cfg_wr = 1'b1;
      cfg_data = d;
      @(posedge ref_clk);
      #1 cfg_wr = 1'b0;
   endtask

   task automatic op(input logic w, two, sy, input logic [23:0] a,
                     input logic [15:0] d);
      int i;
      @(posedge ref_clk);
      #1 req = 1'b1;
      {req_write, req_two, req_sync, req_addr, req_wdata} = {w, two, sy, a, d};
      @(posedge ref_clk);
      #1 req = 1'b0;
      chk({23'h0, busy}, 24'h1);
      for (i = 0; i < 300 && done_q !== 1'b1; i++)
         @(posedge ref_clk) #1;
      if (i == 300)
      begin
         n_fail++;
         $display("mismatch t=%0t no done from host", $time);
         tally_and_finish();
      end
      else
         repeat (3) @(posedge ref_clk);
   endtask

   initial
   begin
      repeat (20) @(posedge ref_clk);
      #1 rst = 1'b0;
      chk({8'h0, cfg_q}, 24'h8000);
      op(0, 1, 0, 24'h12_3456, 16'h0);
      chk(s_addr, 24'h00_3456);
      chk({8'h0, rd_data_q}, 24'h3456 ^ 24'h5a5a);
      $display("plain mode test done");
      cfg(16'h8010);
      op(0, 1, 0, 24'h7f_1234, 16'h0);
      chk(s_addr, 24'h7f_1234);
      op(0, 0, 0, 24'h00_beef, 16'h0);
      chk(s_addr, 24'h7f_beef);
      chk({8'h0, rd_data_q}, 24'hbeef ^ 24'h5a5a);
      op(1, 1, 0, 24'h3c_0042, 16'habcd);
      chk(w_addr, 24'h3c_0042);
      chk({8'h0, w_data}, 24'habcd);
      // write strobe comes after the lower latch, so sensing starts too
      chk(s_cnt, 24'h4);
      cfg(16'h8000);
      cfg(16'h8010);
      op(0, 0, 0, 24'h00_0777, 16'h0);
      chk(s_addr, 24'h00_0777);
      $display("async test done");
      cfg(16'h1010);
      op(0, 1, 1, 24'h05_0a0a, 16'h0);
      chk(s_addr, 24'h05_0a0a);
      chk({8'h0, rd_data_q}, 24'h0a0a ^ 24'h5a5a);
      op(0, 0, 1, 24'h00_c0de, 16'h0);
      chk(s_addr, 24'h05_c0de);
      chk({8'h0, rd_data_q}, 24'hc0de ^ 24'h5a5a);
      op(1, 1, 1, 24'h06_0001, 16'h1234);
      chk(w_addr, 24'h06_0001);
      chk({8'h0, w_data}, 24'h1234);
      $display("sync test done");
      tally_and_finish();
   end
endmodule
